// ### hdl/add_clamp_unit.sv
`timescale 1ns/1ps
`default_nettype none
module add_clamp_unit (
    exec_if.alu ex
);
    logic [add_pkg::WORD_W-1:0] b_eff;
    logic [add_pkg::WORD_W:0] sum;
    logic [add_pkg::WORD_W-1:0] raw;

    always_comb begin
        b_eff = ex.sub ? ~ex.b : ex.b;
        sum = {1'h0, ex.a} + {1'h0, b_eff} + {{add_pkg::WORD_W{1'h0}}, ex.sub};
        raw = sum[add_pkg::MSB:0];
        // subtract reports borrow, so the raw carry is inverted
        ex.carry = sum[add_pkg::WORD_W] ^ ex.sub;
        ex.overflow = (ex.a[add_pkg::MSB] == b_eff[add_pkg::MSB])
                      && (raw[add_pkg::MSB] != ex.a[add_pkg::MSB]);
        ex.clamped = ex.clamp && ex.overflow;
        if (ex.clamped) begin
            ex.result = ex.a[add_pkg::MSB] ? add_pkg::CLAMP_MIN : add_pkg::CLAMP_MAX;
        end else begin
            ex.result = raw;
        end
        ex.sign = ex.result[add_pkg::MSB];
        ex.zero = ex.result == add_pkg::ZERO_WORD;
    end
endmodule : add_clamp_unit
`default_nettype wire

// ### hdl/add_decoder.sv
`timescale 1ns/1ps
`default_nettype none
module add_decoder (
    exec_if.decoder ex
);
    logic [5:0] opc;

    always_comb begin
        opc = ex.instr[add_pkg::OPC_HI:add_pkg::OPC_LO];
        ex.dst = ex.instr[add_pkg::DST_HI:add_pkg::DST_LO];
        ex.src = ex.instr[add_pkg::SRC_HI:add_pkg::SRC_LO];
        ex.op = add_pkg::OP_NONE;
        ex.imm = add_pkg::ZERO_WORD;
        ex.use_imm = 1'h0;
        ex.a_from_src = 1'h0;
        case (opc)
            add_pkg::OPC_ADD_RR: begin
                ex.op = add_pkg::OP_ADD_RR;
            end
            add_pkg::OPC_ADD_SHORT_IMMEDIATE: begin
                ex.op = add_pkg::OP_ADD_SHORT_IMMEDIATE;
                ex.use_imm = 1'h1;
                ex.imm = {{(add_pkg::WORD_W - add_pkg::SHORT_IMM_W){ex.instr[add_pkg::SRC_HI]}},
                          ex.instr[add_pkg::SRC_HI:add_pkg::SRC_LO]};
            end
            add_pkg::OPC_ADD_LONG_IMMEDIATE: begin
                ex.op = add_pkg::OP_ADD_LONG_IMMEDIATE;
                ex.use_imm = 1'h1;
                ex.a_from_src = 1'h1;
                ex.imm = {{(add_pkg::WORD_W - add_pkg::LONG_IMM_W){ex.instr[add_pkg::LONG_IMMEDIATE_HI]}},
                          ex.instr[add_pkg::LONG_IMMEDIATE_HI:add_pkg::LONG_IMMEDIATE_LO]};
            end
            default: begin
                ex.op = add_pkg::OP_NONE;
            end
        endcase
    end
endmodule : add_decoder
`default_nettype wire

// ### hdl/add_pkg.sv
package add_pkg;
    localparam int WORD_W = 32;
    localparam int MSB = WORD_W - 1;
    localparam int REG_IDX_W = 5;
    localparam int REG_COUNT = 32;
    localparam int ADDR_W = 8;
    localparam int STRB_W = WORD_W / 8;
    localparam int SHORT_IMM_W = 5;
    localparam int LONG_IMM_W = 16;

    // instruction word fields
    localparam int DST_HI = 15;
    localparam int DST_LO = 11;
    localparam int OPC_HI = 10;
    localparam int OPC_LO = 5;
    localparam int SRC_HI = 4;
    localparam int SRC_LO = 0;
    localparam int LONG_IMMEDIATE_HI = 31;
    localparam int LONG_IMMEDIATE_LO = 16;

    localparam logic [5:0] OPC_ADD_RR = 6'h0E;
    localparam logic [5:0] OPC_ADD_SHORT_IMMEDIATE = 6'h12;
    localparam logic [5:0] OPC_ADD_LONG_IMMEDIATE = 6'h30;

    typedef enum logic [1:0] {
        OP_NONE,
        OP_ADD_RR,
        OP_ADD_SHORT_IMMEDIATE,
        OP_ADD_LONG_IMMEDIATE
    } op_type;

    // register map, byte addresses
    localparam logic [ADDR_W-1:0] OFF_INSTR = 8'h00;
    localparam logic [ADDR_W-1:0] OFF_FLAGS = 8'h04;
    localparam logic [ADDR_W-1:0] OFF_MODE = 8'h08;
    localparam logic [ADDR_W-1:0] OFF_SEL = 8'h0C;
    localparam logic [ADDR_W-1:0] OFF_GPR = 8'h10;
    localparam logic [ADDR_W-1:0] OFF_COUNT = 8'h14;

    // flag register bit positions
    localparam int FLAG_Z = 0;
    localparam int FLAG_S = 1;
    localparam int FLAG_OV = 2;
    localparam int FLAG_CY = 3;
    localparam int FLAG_SAT = 4;
    localparam int FLAG_BAD = 8;

    // mode register bit positions
    localparam int MODE_CLAMP = 0;
    localparam int MODE_SUB = 1;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    localparam logic [WORD_W-1:0] ZERO_WORD = 32'h0000_0000;
    localparam logic [WORD_W-1:0] CLAMP_MAX = 32'h7FFF_FFFF;
    localparam logic [WORD_W-1:0] CLAMP_MIN = 32'h8000_0000;
endpackage : add_pkg

// ### hdl/exec_if.sv
`timescale 1ns/1ps
`default_nettype none
interface exec_if;
    logic [add_pkg::WORD_W-1:0] instr;
    add_pkg::op_type op;
    logic [add_pkg::REG_IDX_W-1:0] dst;
    logic [add_pkg::REG_IDX_W-1:0] src;
    logic [add_pkg::WORD_W-1:0] imm;
    logic use_imm;
    logic a_from_src;
    logic [add_pkg::WORD_W-1:0] a;
    logic [add_pkg::WORD_W-1:0] b;
    logic sub;
    logic clamp;
    logic [add_pkg::WORD_W-1:0] result;
    logic carry;
    logic overflow;
    logic sign;
    logic zero;
    logic clamped;

    modport decoder (input instr, output op, dst, src, imm, use_imm, a_from_src);
    modport alu (input a, b, sub, clamp, output result, carry, overflow, sign, zero, clamped);
endinterface : exec_if
`default_nettype wire

// ### hdl/integer_add_datapath.sv
// Implementation choices: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
// Contract
// - register add sums source into destination
// - register add opcode is 001110
// - short immediate sign-extended, added to destination
// - short immediate add opcode is 010010
// - carry flag from carry out of MSB
// - overflow flag on signed overflow
// - sign flag copies result top bit
// - zero flag when result is zero
// - plain adds leave saturation flag unchanged
// - clamped results stop at signed limits
// - short forms use 16-bit encoding
// - long immediate form uses 32-bit encoding
module integer_add_datapath (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [add_pkg::ADDR_W-1:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [add_pkg::WORD_W-1:0] wdata,
    input wire logic [add_pkg::STRB_W-1:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [add_pkg::ADDR_W-1:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [add_pkg::WORD_W-1:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready
);
    localparam int W = add_pkg::WORD_W;

    exec_if ex();

    add_decoder dec_u (
        .ex(ex.decoder)
    );

    add_clamp_unit alu_u (
        .ex(ex.alu)
    );

    // write channel state
    logic aw_held, next_aw_held;
    logic w_held, next_w_held;
    logic [add_pkg::ADDR_W-1:0] aw_addr, next_aw_addr;
    logic [W-1:0] w_data, next_w_data;
    logic [add_pkg::STRB_W-1:0] w_strb, next_w_strb;
    logic next_bvalid;
    logic [1:0] next_bresp;
    // read channel state
    logic next_rvalid;
    logic [W-1:0] next_rdata;
    logic [1:0] next_rresp;
    // core state
    logic [W-1:0] instr_word, next_instr_word;
    logic exec_go, next_exec_go;
    logic carry_flag, next_carry_flag;
    logic overflow_flag, next_overflow_flag;
    logic sign_flag, next_sign_flag;
    logic zero_flag, next_zero_flag;
    logic clamp_sticky_flag, next_clamp_sticky_flag;
    logic undecoded_flag, next_undecoded_flag;
    logic mode_clamp, next_mode_clamp;
    logic mode_sub, next_mode_sub;
    logic [add_pkg::REG_IDX_W-1:0] gpr_sel, next_gpr_sel;
    logic [W-1:0] exec_count, next_exec_count;
    logic [W-1:0] gpr [add_pkg::REG_COUNT];
    logic [W-1:0] next_gpr [add_pkg::REG_COUNT];

    logic aw_take, w_take, have_aw, have_w, do_write, wr_hit;
    logic [add_pkg::ADDR_W-1:0] cur_addr;
    logic [W-1:0] cur_data, wmask, flags_word, mode_word, rd_word;
    logic [add_pkg::STRB_W-1:0] cur_strb;
    logic rd_hit, commit;

    function automatic logic [W-1:0] merge(input logic [W-1:0] old, input logic [W-1:0] val,
                                           input logic [W-1:0] mask);
        merge = (old & ~mask) | (val & mask);
    endfunction : merge

    always_comb begin
        flags_word = add_pkg::ZERO_WORD;
        flags_word[add_pkg::FLAG_Z] = zero_flag;
        flags_word[add_pkg::FLAG_S] = sign_flag;
        flags_word[add_pkg::FLAG_OV] = overflow_flag;
        flags_word[add_pkg::FLAG_CY] = carry_flag;
        flags_word[add_pkg::FLAG_SAT] = clamp_sticky_flag;
        flags_word[add_pkg::FLAG_BAD] = undecoded_flag;
        mode_word = add_pkg::ZERO_WORD;
        mode_word[add_pkg::MODE_CLAMP] = mode_clamp;
        mode_word[add_pkg::MODE_SUB] = mode_sub;
    end

    // write channel: address and data taken in either order, response after both
    assign awready = !aw_held && !bvalid;
    assign wready = !w_held && !bvalid;
    assign aw_take = awvalid && awready;
    assign w_take = wvalid && wready;
    assign have_aw = aw_held || aw_take;
    assign have_w = w_held || w_take;
    assign do_write = have_aw && have_w;
    assign cur_addr = aw_held ? aw_addr : awaddr;
    assign cur_data = w_held ? w_data : wdata;
    assign cur_strb = w_held ? w_strb : wstrb;

    always_comb begin
        wmask = add_pkg::ZERO_WORD;
        for (int i = 0; i < add_pkg::STRB_W; i++) begin
            wmask[i*8 +: 8] = {8{cur_strb[i]}};
        end
        case (cur_addr)
            add_pkg::OFF_INSTR, add_pkg::OFF_FLAGS, add_pkg::OFF_MODE,
            add_pkg::OFF_SEL, add_pkg::OFF_GPR, add_pkg::OFF_COUNT: wr_hit = 1'h1;
            default: wr_hit = 1'h0;
        endcase
        next_aw_held = do_write ? 1'h0 : have_aw;
        next_w_held = do_write ? 1'h0 : have_w;
        next_aw_addr = aw_take ? awaddr : aw_addr;
        next_w_data = w_take ? wdata : w_data;
        next_w_strb = w_take ? wstrb : w_strb;
        next_bvalid = bvalid;
        next_bresp = bresp;
        if (do_write) begin
            next_bvalid = 1'h1;
            next_bresp = wr_hit ? add_pkg::RESP_OKAY : add_pkg::RESP_SLVERR;
        end else if (bready) begin
            next_bvalid = 1'h0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'h0;
            w_held <= 1'h0;
            aw_addr <= '0;
            w_data <= add_pkg::ZERO_WORD;
            w_strb <= '0;
            bvalid <= 1'h0;
            bresp <= add_pkg::RESP_OKAY;
        end else begin
            aw_held <= next_aw_held;
            w_held <= next_w_held;
            aw_addr <= next_aw_addr;
            w_data <= next_w_data;
            w_strb <= next_w_strb;
            bvalid <= next_bvalid;
            bresp <= next_bresp;
        end
    end

    // read channel
    assign arready = !rvalid;

    always_comb begin
        rd_hit = 1'h1;
        case (araddr)
            add_pkg::OFF_INSTR: rd_word = instr_word;
            add_pkg::OFF_FLAGS: rd_word = flags_word;
            add_pkg::OFF_MODE: rd_word = mode_word;
            add_pkg::OFF_SEL: rd_word = {{(W - add_pkg::REG_IDX_W){1'h0}}, gpr_sel};
            add_pkg::OFF_GPR: rd_word = gpr[gpr_sel];
            add_pkg::OFF_COUNT: rd_word = exec_count;
            default: begin
                rd_word = add_pkg::ZERO_WORD;
                rd_hit = 1'h0;
            end
        endcase
        next_rvalid = rvalid;
        next_rdata = rdata;
        next_rresp = rresp;
        if (arvalid && arready) begin
            next_rvalid = 1'h1;
            next_rdata = rd_word;
            next_rresp = rd_hit ? add_pkg::RESP_OKAY : add_pkg::RESP_SLVERR;
        end else if (rready) begin
            next_rvalid = 1'h0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid <= 1'h0;
            rdata <= add_pkg::ZERO_WORD;
            rresp <= add_pkg::RESP_OKAY;
        end else begin
            rvalid <= next_rvalid;
            rdata <= next_rdata;
            rresp <= next_rresp;
        end
    end

    // execute: operands from the register file or the decoded immediate, result and flags in the same cycle
    assign ex.instr = instr_word;
    assign ex.a = ex.a_from_src ? gpr[ex.src] : gpr[ex.dst];
    assign ex.b = ex.use_imm ? ex.imm : gpr[ex.src];
    assign ex.clamp = (ex.op == add_pkg::OP_ADD_RR) && mode_clamp;
    assign ex.sub = ex.clamp && mode_sub;
    assign commit = exec_go && (ex.op != add_pkg::OP_NONE);

    always_comb begin
        next_gpr = gpr;
        next_instr_word = instr_word;
        next_exec_go = 1'h0;
        next_carry_flag = carry_flag;
        next_overflow_flag = overflow_flag;
        next_sign_flag = sign_flag;
        next_zero_flag = zero_flag;
        next_clamp_sticky_flag = clamp_sticky_flag;
        next_undecoded_flag = undecoded_flag;
        next_mode_clamp = mode_clamp;
        next_mode_sub = mode_sub;
        next_gpr_sel = gpr_sel;
        next_exec_count = exec_count;
        // bus writes never meet an execute cycle: bvalid blocks the next write
        if (do_write) begin
            case (cur_addr)
                add_pkg::OFF_INSTR: begin
                    next_instr_word = merge(instr_word, cur_data, wmask);
                    next_exec_go = 1'h1;
                end
                add_pkg::OFF_FLAGS: begin
                    if (cur_strb[0]) begin
                        next_zero_flag = cur_data[add_pkg::FLAG_Z];
                        next_sign_flag = cur_data[add_pkg::FLAG_S];
                        next_overflow_flag = cur_data[add_pkg::FLAG_OV];
                        next_carry_flag = cur_data[add_pkg::FLAG_CY];
                        next_clamp_sticky_flag = cur_data[add_pkg::FLAG_SAT];
                    end
                    if (cur_strb[1]) begin
                        next_undecoded_flag = cur_data[add_pkg::FLAG_BAD];
                    end
                end
                add_pkg::OFF_MODE: begin
                    if (cur_strb[0]) begin
                        next_mode_clamp = cur_data[add_pkg::MODE_CLAMP];
                        next_mode_sub = cur_data[add_pkg::MODE_SUB];
                    end
                end
                add_pkg::OFF_SEL: begin
                    if (cur_strb[0]) begin
                        next_gpr_sel = cur_data[add_pkg::REG_IDX_W-1:0];
                    end
                end
                add_pkg::OFF_GPR: next_gpr[gpr_sel] = merge(gpr[gpr_sel], cur_data, wmask);
                default: next_exec_count = exec_count;
            endcase
        end
        if (commit) begin
            next_gpr[ex.dst] = ex.result;
            next_carry_flag = ex.carry;
            next_overflow_flag = ex.overflow;
            next_sign_flag = ex.sign;
            next_zero_flag = ex.zero;
            // plain adds never touch the sticky flag
            if (ex.clamped) begin
                next_clamp_sticky_flag = 1'h1;
            end
            next_exec_count = exec_count + 32'h0000_0001;
        end else if (exec_go) begin
            next_undecoded_flag = 1'h1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            for (int i = 0; i < add_pkg::REG_COUNT; i++) begin
                gpr[i] <= add_pkg::ZERO_WORD;
            end
            instr_word <= add_pkg::ZERO_WORD;
            exec_go <= 1'h0;
            carry_flag <= 1'h0;
            overflow_flag <= 1'h0;
            sign_flag <= 1'h0;
            zero_flag <= 1'h0;
            clamp_sticky_flag <= 1'h0;
            undecoded_flag <= 1'h0;
            mode_clamp <= 1'h0;
            mode_sub <= 1'h0;
            gpr_sel <= '0;
            exec_count <= add_pkg::ZERO_WORD;
        end else begin
            gpr <= next_gpr;
            instr_word <= next_instr_word;
            exec_go <= next_exec_go;
            carry_flag <= next_carry_flag;
            overflow_flag <= next_overflow_flag;
            sign_flag <= next_sign_flag;
            zero_flag <= next_zero_flag;
            clamp_sticky_flag <= next_clamp_sticky_flag;
            undecoded_flag <= next_undecoded_flag;
            mode_clamp <= next_mode_clamp;
            mode_sub <= next_mode_sub;
            gpr_sel <= next_gpr_sel;
            exec_count <= next_exec_count;
        end
    end

    // reference model taken straight from the instruction word
    logic [5:0] ref_opc;
    logic [add_pkg::REG_IDX_W-1:0] ref_dst, ref_src;
    logic [W-1:0] ref_a, ref_b, src_val;
    logic [W:0] ref_sum;
    logic ref_ov;

    always_comb begin
        ref_opc = instr_word[add_pkg::OPC_HI:add_pkg::OPC_LO];
        ref_dst = instr_word[add_pkg::DST_HI:add_pkg::DST_LO];
        ref_src = instr_word[add_pkg::SRC_HI:add_pkg::SRC_LO];
        src_val = gpr[ref_src];
        ref_a = (ref_opc == add_pkg::OPC_ADD_LONG_IMMEDIATE) ? gpr[ref_src] : gpr[ref_dst];
        case (ref_opc)
            add_pkg::OPC_ADD_SHORT_IMMEDIATE: ref_b = W'($signed(instr_word[add_pkg::SRC_HI:add_pkg::SRC_LO]));
            add_pkg::OPC_ADD_LONG_IMMEDIATE:
                ref_b = W'($signed(instr_word[add_pkg::LONG_IMMEDIATE_HI:add_pkg::LONG_IMMEDIATE_LO]));
            default: ref_b = gpr[ref_src];
        endcase
        ref_sum = {1'h0, ref_a} + {1'h0, ref_b};
        ref_ov = (ref_a[add_pkg::MSB] == ref_b[add_pkg::MSB])
                 && (ref_sum[add_pkg::MSB] != ref_a[add_pkg::MSB]);
    end

    rr_sum_a: assert property (@(posedge aclk) disable iff (!aresetn)
        exec_go && ref_opc == add_pkg::OPC_ADD_RR && !mode_clamp
        |=> gpr[$past(ref_dst)] == $past(ref_sum[add_pkg::MSB:0]))
        else $error("register add result wrong");
    src_keep_a: assert property (@(posedge aclk) disable iff (!aresetn)
        commit && ref_src != ref_dst |=> gpr[$past(ref_src)] == $past(src_val))
        else $error("source register altered");
    rr_decode_a: assert property (@(posedge aclk) disable iff (!aresetn)
        exec_go && ref_opc == add_pkg::OPC_ADD_RR
        |-> ex.op == add_pkg::OP_ADD_RR && ex.dst == ref_dst && ex.src == ref_src)
        else $error("register add not decoded");
    short_immediate_sum_a: assert property (@(posedge aclk) disable iff (!aresetn)
        exec_go && ref_opc == add_pkg::OPC_ADD_SHORT_IMMEDIATE
        |=> gpr[$past(ref_dst)] == $past(ref_sum[add_pkg::MSB:0]))
        else $error("short immediate add result wrong");
    short_immediate_decode_a: assert property (@(posedge aclk) disable iff (!aresetn)
        exec_go && ref_opc == add_pkg::OPC_ADD_SHORT_IMMEDIATE |-> ex.op == add_pkg::OP_ADD_SHORT_IMMEDIATE)
        else $error("short immediate add not decoded");
    carry_flag_a: assert property (@(posedge aclk) disable iff (!aresetn)
        commit && !ex.sub |=> carry_flag == $past(ref_sum[W]))
        else $error("carry flag wrong");
    ovf_flag_a: assert property (@(posedge aclk) disable iff (!aresetn)
        commit && !ex.sub |=> overflow_flag == $past(ref_ov))
        else $error("overflow flag wrong");
    sign_flag_a: assert property (@(posedge aclk) disable iff (!aresetn)
        commit |=> sign_flag == gpr[$past(ref_dst)][add_pkg::MSB])
        else $error("sign flag wrong");
    zero_flag_a: assert property (@(posedge aclk) disable iff (!aresetn)
        commit |=> zero_flag == (gpr[$past(ref_dst)] == add_pkg::ZERO_WORD))
        else $error("zero flag wrong");
    sat_keep_a: assert property (@(posedge aclk) disable iff (!aresetn)
        commit && !ex.clamp |=> $stable(clamp_sticky_flag))
        else $error("saturation flag changed by add");
    long_immediate_sum_a: assert property (@(posedge aclk) disable iff (!aresetn)
        exec_go && ref_opc == add_pkg::OPC_ADD_LONG_IMMEDIATE
        |=> gpr[$past(ref_dst)] == $past(ref_sum[add_pkg::MSB:0]))
        else $error("long immediate add result wrong");
    long_immediate_decode_a: assert property (@(posedge aclk) disable iff (!aresetn)
        exec_go && ref_opc == add_pkg::OPC_ADD_LONG_IMMEDIATE
        |-> ex.op == add_pkg::OP_ADD_LONG_IMMEDIATE && ex.a_from_src)
        else $error("long immediate add not decoded");
    clamp_hit_a: assert property (@(posedge aclk) disable iff (!aresetn)
        commit && ex.clamp && !ex.sub && ref_ov
        |=> clamp_sticky_flag && gpr[$past(ref_dst)]
            == ($past(ref_a[add_pkg::MSB]) ? add_pkg::CLAMP_MIN : add_pkg::CLAMP_MAX))
        else $error("clamp limit wrong");
    one_cycle_a: assert property (@(posedge aclk) disable iff (!aresetn)
        commit |=> !exec_go && exec_count == $past(exec_count) + 32'h0000_0001)
        else $error("add not finished in one cycle");
endmodule : integer_add_datapath
`default_nettype wire

// ### sim/bus_master_model.sv
`timescale 1ns/1ps
`default_nettype none
module bus_master_model (
    input wire logic aclk,
    output logic [7:0] awaddr,
    output logic awvalid,
    input wire logic awready,
    output logic [31:0] wdata,
    output logic [3:0] wstrb,
    output logic wvalid,
    input wire logic wready,
    input wire logic [1:0] bresp,
    input wire logic bvalid,
    output logic bready,
    output logic [7:0] araddr,
    output logic arvalid,
    input wire logic arready,
    input wire logic [31:0] rdata,
    input wire logic [1:0] rresp,
    input wire logic rvalid,
    output logic rready
);
    initial begin
        {awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
        {araddr, arvalid, rready} = '0;
    end
    // ready and answers read as sampled at the rising edge, before that edge's updates land
    task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        logic pa, pw;
        pa = 1'h1;
        pw = 1'h1;
        @(posedge aclk);
        {awaddr, wdata, wstrb} <= {a, d, 4'hF};
        {awvalid, wvalid, bready} <= 3'h7;
        while (pa || pw) begin
            @(posedge aclk);
            if (pa && awready) begin
                awvalid <= 1'h0;
                pa = 1'h0;
            end
            if (pw && wready) begin
                wvalid <= 1'h0;
                pw = 1'h0;
            end
        end
        do begin
            @(posedge aclk);
        end while (!bvalid);
        r = bresp;
        bready <= 1'h0;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge aclk);
        {araddr, arvalid, rready} <= {a, 2'h3};
        do begin
            @(posedge aclk);
        end while (!arready);
        arvalid <= 1'h0;
        do begin
            @(posedge aclk);
        end while (!rvalid);
        {d, r} = {rdata, rresp};
        rready <= 1'h0;
    endtask : rd
endmodule : bus_master_model
`default_nettype wire

// ### sim/integer_add_datapath_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module integer_add_datapath_tb_top;
    logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata, v;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp, r;
    int bad_count = 0;
    int checked = 0;
    int cycles = 0;
    integer_add_datapath dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
        .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
        .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
        .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
        .rready(rready));
    bus_master_model host (.aclk(aclk), .awaddr(awaddr),
        .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
        .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
        .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
        .rready(rready));
    initial begin
        aclk = 1'h0;
        forever #2.5 aclk = ~aclk;
    end
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : tally_and_finish
    // the whole run needs well under a thousand cycles
    always @(posedge aclk) begin
        cycles++;
        if (cycles == 5000) begin
            bad_count++;
            tally_and_finish();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic put(input logic [4:0] i, input logic [31:0] d);
        host.wr(8'h0C, {27'h0, i}, r);
        host.wr(8'h10, d, r);
    endtask : put
    task automatic get(input logic [4:0] i);
        host.wr(8'h0C, {27'h0, i}, r);
        host.rd(8'h10, v, r);
    endtask : get
    function automatic logic [35:0] ref_add(input logic [31:0] a, input logic [31:0] b);
        logic [32:0] t;
        t = {1'h0, a} + {1'h0, b};
        return {t[32], a[31] == b[31] && t[31] != a[31], t[31], t[31:0] == 32'h0, t[31:0]};
    endfunction : ref_add
    task automatic trial(input logic [5:0] op, input logic [15:0] hi, input logic [4:0] d,
        input logic [4:0] s, input logic [31:0] dv, input logic [31:0] sv,
        input logic [31:0] a, input logic [31:0] b);
        logic [35:0] e;
        e = ref_add(a, b);
        host.wr(8'h04, 32'h10, r);
        put(d, dv);
        put(s, sv);
        host.wr(8'h00, {hi, d, op, s}, r);
        get(d);
        chk(v, e[31:0]);
        host.rd(8'h04, v, r);
        chk({27'h0, v[4:0]}, {27'h0, 1'h1, e[35:32]});
        get(s);
        chk(v, sv);
    endtask : trial
    task automatic clamp(input logic [31:0] m, input logic [31:0] dv, input logic [31:0] e);
        host.wr(8'h08, m, r);
        // sticky bit cleared first, else its check could never trip
        host.wr(8'h04, 32'h0, r);
        put(5'h02, dv);
        put(5'h01, 32'h1);
        host.wr(8'h00, 32'h11C1, r);
        get(5'h02);
        chk(v, e);
        host.rd(8'h04, v, r);
        chk({31'h0, v[4]}, 32'h1);
    endtask : clamp
    initial begin
        aresetn = 1'h0;
        repeat (8) @(posedge aclk);
        aresetn <= 1'h1;
        host.rd(8'h04, v, r);
        chk(v, 32'h0);
        $display("test reset done");
        trial(6'h0E, 16'h0, 5'h02, 5'h01, 32'h1, 32'h7FFFFFFF, 32'h1, 32'h7FFFFFFF);
        trial(6'h0E, 16'h0, 5'h04, 5'h05, 32'hFFFFFFFF, 32'h1, 32'hFFFFFFFF, 32'h1);
        trial(6'h12, 16'h0, 5'h06, 5'h10, 32'hF, 32'h0, 32'hF, 32'hFFFFFFF0);
        trial(6'h12, 16'h0, 5'h07, 5'h0F, 32'h7FFFFFF1, 32'h0, 32'h7FFFFFF1, 32'hF);
        trial(6'h30, 16'h8000, 5'h08, 5'h09, 32'h5, 32'h10000, 32'h10000, 32'hFFFF8000);
        $display("test adds done");
        clamp(32'h1, 32'h7FFFFFFF, 32'h7FFFFFFF);
        clamp(32'h3, 32'h80000000, 32'h80000000);
        $display("test clamp done");
        host.wr(8'h08, 32'h0, r);
        host.wr(8'h00, 32'h1021, r);
        host.rd(8'h04, v, r);
        chk({31'h0, v[8]}, 32'h1);
        host.rd(8'h00, v, r);
        chk(v, 32'h1021);
        host.wr(8'h14, 32'hFF, r);
        chk({30'h0, r}, 32'h0);
        host.rd(8'h14, v, r);
        chk(v, 32'h7);
        host.rd(8'h20, v, r);
        chk({30'h0, r}, 32'h2);
        chk(v, 32'h0);
        host.wr(8'h20, 32'h1, r);
        chk({30'h0, r}, 32'h2);
        $display("test decode done");
        tally_and_finish();
    end
endmodule : integer_add_datapath_tb_top
`default_nettype wire
